/* File: rtl/chsp_check.v */
`timescale 1ns/1ps
`include "chsp_defs.vh"

module chsp_check (
  input  wire [3:0]  param,    // Parameter index
  input  wire [4:0]  itype,    // Channel input type
  input  wire [15:0] wval,     // Candidate value
  input  wire [15:0] cur_shi,  // Stored scale high
  input  wire [15:0] cur_slo,  // Stored scale low
  input  wire [15:0] cur_fhi,  // Stored fault upper
  input  wire [15:0] cur_flo,  // Stored fault lower
  input  wire [15:0] rng_hi,   // Range maximum
  input  wire [15:0] rng_lo,   // Range minimum
  output reg         ok,       // Value accepted
  output wire [15:0] fhi_lim,  // Range high plus margin
  output wire [15:0] flo_lim,  // Range low minus margin
  output wire        is_tcrtd, // Thermocouple or RTD
  output wire        coarse_tc // Whole-degree-only thermocouple
);

  wire signed [17:0] v    = {{2{wval[15]}}, wval};
  wire signed [17:0] shi  = {{2{cur_shi[15]}}, cur_shi};
  wire signed [17:0] slo  = {{2{cur_slo[15]}}, cur_slo};
  wire signed [17:0] fhi  = {{2{cur_fhi[15]}}, cur_fhi};
  wire signed [17:0] flo  = {{2{cur_flo[15]}}, cur_flo};
  wire signed [17:0] rh   = {{2{rng_hi[15]}}, rng_hi};
  wire signed [17:0] rl   = {{2{rng_lo[15]}}, rng_lo};
  wire signed [17:0] mg   = (rh - rl) / `CHSP_MARGIN_DIV;
  wire signed [17:0] fh_l = rh + mg;
  wire signed [17:0] fl_l = rl - mg;
  wire signed [17:0] d_hi = v - slo;
  wire signed [17:0] d_lo = shi - v;

  wire is_tc   = (itype <= `CHSP_T_TC_LAST);
  wire is_rtd  = (itype == `CHSP_T_PT) || (itype == `CHSP_T_JPT);
  wire is_vi   = (itype >= `CHSP_T_VI_FIRST) && (itype <= `CHSP_T_VI_LAST);
  wire fine_tc = (itype == `CHSP_T_K) || (itype == `CHSP_T_J) ||
                 (itype == `CHSP_T_T) || (itype == `CHSP_T_E);
  wire in_vi   = (v >= `CHSP_VI_MIN) && (v <= `CHSP_VI_MAX);

  assign fhi_lim   = fh_l[15:0];
  assign flo_lim   = fl_l[15:0];
  assign is_tcrtd  = is_tc || is_rtd;
  assign coarse_tc = is_tc && !fine_tc;

  always @* begin
    ok = 1'b0;
    case (param)
      `CHSP_P_DP: begin
        if (is_tc && fine_tc)
          ok = (wval <= `CHSP_DP_FINE_MAX);
        else if (is_tc)
          ok = (wval == `CHSP_ZERO16);
        else if (is_rtd)
          ok = (wval <= `CHSP_DP_FINE_MAX);
        else
          ok = (wval <= `CHSP_DP_MAX);
      end
      `CHSP_P_SHI: begin
        if (is_vi)
          ok = in_vi && (d_hi <= `CHSP_SPAN_MAX) && (d_hi >= -`CHSP_SPAN_MAX);
        else
          ok = (v >= slo) && (v <= rh);
      end
      `CHSP_P_SLO: begin
        if (is_vi)
          ok = in_vi && (d_lo <= `CHSP_SPAN_MAX) && (d_lo >= -`CHSP_SPAN_MAX);
        else
          ok = (v >= rl) && (v <= shi);
      end
      `CHSP_P_FHI:  ok = (v >= flo) && (v <= fh_l);
      `CHSP_P_FLO:  ok = (v >= fl_l) && (v <= fhi);
      `CHSP_P_BS:   ok = (wval <= `CHSP_FLAG_MAX);
      `CHSP_P_SQRT: ok = (wval <= `CHSP_FLAG_MAX);
      `CHSP_P_OSEL: ok = (wval <= `CHSP_OSEL_MAX);
      `CHSP_P_POL:  ok = (wval <= `CHSP_FLAG_MAX);
      default:      ok = 1'b0;
    endcase
  end

endmodule // chsp_check

/* File: rtl/chsp_defs.vh */
`ifndef CHSP_DEFS_VH
`define CHSP_DEFS_VH

// ****************************************
// Word addresses
// ****************************************
`define CHSP_BASE_FIRST   16'h19ec
`define CHSP_BASE_DP      16'h19ec
`define CHSP_BASE_SHI     16'h1a2c
`define CHSP_BASE_SLO     16'h1a6c
`define CHSP_BASE_FHI     16'h1aac
`define CHSP_BASE_FLO     16'h1aec
`define CHSP_BASE_BS      16'h1b2c
`define CHSP_BASE_SQRT    16'h1b6c
`define CHSP_BASE_OSEL    16'h1bac
`define CHSP_BASE_POL     16'h1bec
`define CHSP_MAP_WORDS    16'h0240
`define CHSP_MEM_WORDS    576

// ****************************************
// Parameter indices (bits 9:6 of the offset from the first base)
// ****************************************
`define CHSP_P_DP         4'h0
`define CHSP_P_SHI        4'h1
`define CHSP_P_SLO        4'h2
`define CHSP_P_FHI        4'h3
`define CHSP_P_FLO        4'h4
`define CHSP_P_BS         4'h5
`define CHSP_P_SQRT       4'h6
`define CHSP_P_OSEL       4'h7
`define CHSP_P_POL        4'h8

// ****************************************
// Input type codes
// ****************************************
`define CHSP_T_K          5'h00
`define CHSP_T_J          5'h01
`define CHSP_T_E          5'h05
`define CHSP_T_T          5'h07
`define CHSP_T_TC_LAST    5'h09
`define CHSP_T_PT         5'h0c
`define CHSP_T_JPT        5'h0d
`define CHSP_T_VI_FIRST   5'h0e
`define CHSP_T_VL_FIRST   5'h13
`define CHSP_T_VI_LAST    5'h15

// ****************************************
// Values and limits
// ****************************************
`define CHSP_DP_MAX       16'h0004
`define CHSP_DP_FINE_MAX  16'h0001
`define CHSP_DP_DEF       16'h0001
`define CHSP_FLAG_MAX     16'h0001
`define CHSP_OSEL_MAX     16'h0002
`define CHSP_OSEL_CTRL    2'h0
`define CHSP_OSEL_LOGIC   2'h1
`define CHSP_OSEL_FAIL    2'h2
`define CHSP_VI_MAX       18'sh04e1f
`define CHSP_VI_MIN       18'sh3b1e1
`define CHSP_SPAN_MAX     18'sh04e20
`define CHSP_MARGIN_DIV   18'sh00014
`define CHSP_VI_SHI_DEF   16'h03e8
`define CHSP_VI_SLO_DEF   16'h0000
`define CHSP_ZERO16       16'h0000

`endif

/* File: rtl/chsp_param_bank.v */
`timescale 1ns/1ps
`include "chsp_defs.vh"

module chsp_param_bank #(
  parameter N_CH = 64                    // Channels, at most 64
) (
  input  wire              mclk,         // System clock
  input  wire              rst_n,        // Synchronous reset, active low
  input  wire [15:0]       reg_addr,     // Word address
  input  wire [15:0]       reg_wdata,    // Write data
  input  wire              reg_wr,       // Write strobe
  input  wire              reg_rd,       // Read strobe
  output reg  [15:0]       reg_rdata,    // Read data
  output reg               reg_ack,      // Access done pulse
  output reg               reg_err,      // Unmapped or rejected pulse
  output reg               reg_busy,     // Defaults loading
  input  wire [N_CH*5-1:0] type_bus,     // Input type per channel
  input  wire [N_CH*16-1:0] range_hi_bus, // Range maximum per channel
  input  wire [N_CH*16-1:0] range_lo_bus, // Range minimum per channel
  input  wire [N_CH-1:0]   ctrl_in,      // Control output per channel
  input  wire [N_CH-1:0]   logic_in,     // Logic result per channel
  input  wire [N_CH-1:0]   fail_in,      // Failure indication per channel
  output reg  [N_CH-1:0]   chan_out,     // Routed output per channel
  output reg  [N_CH-1:0]   burnout_down, // Effective downscale burnout
  output reg  [N_CH-1:0]   sqrt_en,      // Square root enabled
  output reg  [N_CH*3-1:0] dp_bus        // Decimal places per channel
);

  // ****************************************
  // State
  // ****************************************
  localparam ST_INIT = 1'b0;
  localparam ST_IDLE = 1'b1;

  reg        state_r;
  reg        state_nxt;
  reg  [5:0] init_ch_r;
  reg  [5:0] init_ch_nxt;
  reg [15:0] mem [0:`CHSP_MEM_WORDS-1];

  // ****************************************
  // Address decode
  // ****************************************
  wire [15:0] off    = reg_addr - `CHSP_BASE_FIRST;
  wire [3:0]  prm    = off[9:6];
  wire [5:0]  req_ch = off[5:0];
  reg         mapped;

  always @* begin
    if (reg_addr < `CHSP_BASE_FIRST)
      mapped = 1'b0;
    else if (off >= `CHSP_MAP_WORDS)
      mapped = 1'b0;
    else if ({26'h0000000, req_ch} >= N_CH)
      mapped = 1'b0;
    else
      mapped = 1'b1;
  end

  wire        in_init = (state_r == ST_INIT);
  wire [5:0]  ck_ch   = in_init ? init_ch_r : req_ch;

  // ****************************************
  // Limit checker
  // ****************************************
  wire [4:0]  ck_type = type_bus[ck_ch*5 +: 5];
  wire [15:0] ck_rh   = range_hi_bus[ck_ch*16 +: 16];
  wire [15:0] ck_rl   = range_lo_bus[ck_ch*16 +: 16];
  wire [15:0] cur_shi = mem[{`CHSP_P_SHI, ck_ch}];
  wire [15:0] cur_slo = mem[{`CHSP_P_SLO, ck_ch}];
  wire [15:0] cur_fhi = mem[{`CHSP_P_FHI, ck_ch}];
  wire [15:0] cur_flo = mem[{`CHSP_P_FLO, ck_ch}];
  wire        wr_ok;
  wire [15:0] fhi_lim;
  wire [15:0] flo_lim;
  wire        is_tcrtd;
  wire        coarse_tc;

  chsp_check u_check (
    .param     (prm),
    .itype     (ck_type),
    .wval      (reg_wdata),
    .cur_shi   (cur_shi),
    .cur_slo   (cur_slo),
    .cur_fhi   (cur_fhi),
    .cur_flo   (cur_flo),
    .rng_hi    (ck_rh),
    .rng_lo    (ck_rl),
    .ok        (wr_ok),
    .fhi_lim   (fhi_lim),
    .flo_lim   (flo_lim),
    .is_tcrtd  (is_tcrtd),
    .coarse_tc (coarse_tc)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_nxt   = state_r;
    init_ch_nxt = init_ch_r;
    case (state_r)
      ST_INIT: begin
        init_ch_nxt = init_ch_r + 6'h01;
        if ({26'h0000000, init_ch_r} == N_CH - 1)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_r   <= ST_INIT;
      init_ch_r <= 6'h00;
      reg_busy  <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      init_ch_r <= init_ch_nxt;
      reg_busy  <= (state_nxt == ST_INIT);
    end
  end

  // ****************************************
  // Parameter storage
  // ****************************************
  // Defaults follow the range inputs, so they load one channel a cycle
  // after reset instead of being frozen constants.
  wire do_wr = !in_init && reg_wr && mapped && wr_ok;

  always @(posedge mclk) begin
    if (rst_n && in_init) begin
      mem[{`CHSP_P_DP, init_ch_r}]   <= coarse_tc ? `CHSP_ZERO16 : `CHSP_DP_DEF;
      // V/I default 100.0 at one decimal place
      mem[{`CHSP_P_SHI, init_ch_r}]  <= is_tcrtd ? ck_rh : `CHSP_VI_SHI_DEF;
      mem[{`CHSP_P_SLO, init_ch_r}]  <= is_tcrtd ? ck_rl : `CHSP_VI_SLO_DEF;
      mem[{`CHSP_P_FHI, init_ch_r}]  <= fhi_lim;
      mem[{`CHSP_P_FLO, init_ch_r}]  <= flo_lim;
      mem[{`CHSP_P_BS, init_ch_r}]   <= `CHSP_ZERO16;
      mem[{`CHSP_P_SQRT, init_ch_r}] <= `CHSP_ZERO16;
      mem[{`CHSP_P_OSEL, init_ch_r}] <= `CHSP_ZERO16;
      mem[{`CHSP_P_POL, init_ch_r}]  <= `CHSP_ZERO16;
    end else if (do_wr) begin
      mem[{prm, req_ch}] <= reg_wdata;
    end
  end

  // ****************************************
  // Register port answer
  // ****************************************
  // Write wins when both strobes are raised together.
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
    end else if (in_init) begin
      reg_rdata <= 16'h0000;
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
    end else if (reg_wr) begin
      reg_rdata <= 16'h0000;
      reg_ack   <= 1'b1;
      reg_err   <= !(mapped && wr_ok);
    end else if (reg_rd) begin
      reg_rdata <= mapped ? mem[{prm, req_ch}] : 16'h0000;
      reg_ack   <= 1'b1;
      reg_err   <= !mapped;
    end else begin
      reg_rdata <= reg_rdata;
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
    end
  end

  // ****************************************
  // Per-channel outputs
  // ****************************************
  genvar c;
  generate
    for (c = 0; c < N_CH; c = c + 1) begin : g_ch
      // A genvar cannot be bit-selected, so take the channel as a sized constant
      localparam [5:0] CH_IDX = c;
      wire [15:0] osel_w = mem[{`CHSP_P_OSEL, CH_IDX}];
      wire [15:0] pol_w  = mem[{`CHSP_P_POL, CH_IDX}];
      wire [15:0] bs_w   = mem[{`CHSP_P_BS, CH_IDX}];
      wire [15:0] sq_w   = mem[{`CHSP_P_SQRT, CH_IDX}];
      wire [15:0] dp_w   = mem[{`CHSP_P_DP, CH_IDX}];
      wire [4:0]  ty_w   = type_bus[c*5 +: 5];
      wire        burn_ok = (ty_w <= `CHSP_T_TC_LAST) ||
                            ((ty_w >= `CHSP_T_VL_FIRST) && (ty_w <= `CHSP_T_VI_LAST));
      reg         src;

      always @* begin
        case (osel_w[1:0])
          `CHSP_OSEL_CTRL:  src = ctrl_in[c];
          `CHSP_OSEL_LOGIC: src = logic_in[c];
          `CHSP_OSEL_FAIL:  src = fail_in[c];
          default:          src = 1'b0;
        endcase
      end

      always @(posedge mclk) begin
        if (!rst_n || in_init) begin
          chan_out[c]       <= 1'b0;
          burnout_down[c]   <= 1'b0;
          sqrt_en[c]        <= 1'b0;
          dp_bus[c*3 +: 3]  <= 3'h0;
        end else begin
          chan_out[c]       <= src ^ pol_w[0];
          burnout_down[c]   <= bs_w[0] && burn_ok;
          sqrt_en[c]        <= sq_w[0];
          dp_bus[c*3 +: 3]  <= dp_w[2:0];
        end
      end
    end
  endgenerate

endmodule // chsp_param_bank

/* File: testbench/chsp_host.sv */
`timescale 1ns/1ps
module chsp_host (
  input  wire        mclk,      // Clock
  output reg  [15:0] reg_addr,  // Address
  output reg  [15:0] reg_wdata, // Write data
  output reg         reg_wr,    // Write
  output reg         reg_rd,    // Read
  input  wire [15:0] reg_rdata, // Read data
  input  wire        reg_ack,   // Ack
  input  wire        reg_err    // Error
);
  // ****************************************
  // Word access
  // ****************************************
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task acc(input logic w, input logic [15:0] a, d, output logic [15:0] q, output logic k, e);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Released lines must not keep the old value
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge mclk);
    q = reg_rdata;
    k = reg_ack;
    e = reg_err;
  endtask
endmodule // chsp_host

/* File: testbench/chsp_param_bank_checker.sv */
`timescale 1ns/1ps
module chsp_chk #(
  parameter N_CH = 4                     // Channels
) (
  input wire               mclk,         // Clock
  input wire               rst_n,        // Reset
  input wire [15:0]        reg_addr,     // Address
  input wire [15:0]        reg_wdata,    // Write data
  input wire               reg_wr,       // Write
  input wire               reg_rd,       // Read
  input wire [15:0]        reg_rdata,    // Read data
  input wire               reg_ack,      // Ack
  input wire               reg_err,      // Error
  input wire               reg_busy,     // Busy
  input wire [N_CH*5-1:0]  type_bus,     // Types
  input wire [N_CH*16-1:0] range_hi_bus, // Range max
  input wire [N_CH*16-1:0] range_lo_bus, // Range min
  input wire [N_CH-1:0]    ctrl_in,      // Control
  input wire [N_CH-1:0]    logic_in,     // Logic
  input wire [N_CH-1:0]    fail_in,      // Fail
  input wire [N_CH-1:0]    chan_out,     // Output
  input wire [N_CH-1:0]    burnout_down, // Burnout
  input wire [N_CH-1:0]    sqrt_en,      // Root
  input wire [N_CH*3-1:0]  dp_bus        // Places
);
  // ****************************************
  // Port checks
  // ****************************************
  wire       take = !reg_busy && (reg_wr || reg_rd);
  wire       wt   = !reg_busy && reg_wr;
  wire       rt   = !reg_busy && reg_rd && !reg_wr;
  reg  [7:0] bcnt_r;
  always @(posedge mclk) bcnt_r <= (!rst_n || !reg_busy) ? 8'h00 : bcnt_r + 8'h01;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_take; take; endsequence
  sequence s_bad_dp; wt && reg_addr >= 16'h19ec && reg_addr < 16'h1a2c && reg_wdata > 16'h0004;
  endsequence
  sequence s_bad_flag; wt && reg_addr >= 16'h1b2c && reg_addr < 16'h1bac && reg_wdata > 16'h0001;
  endsequence
  sequence s_bad_osel; wt && reg_addr >= 16'h1bac && reg_addr < 16'h1bec && reg_wdata > 16'h0002;
  endsequence
  property p_ack; s_take |=> reg_ack; endproperty
  property p_spur; reg_ack |-> $past(take); endproperty
  property p_err; reg_err |-> reg_ack; endproperty
  property p_dp; s_bad_dp |=> reg_err; endproperty
  property p_flag; s_bad_flag |=> reg_err; endproperty
  property p_osel; s_bad_osel |=> reg_err; endproperty
  property p_unmap; rt && reg_addr < 16'h19ec |=> reg_err && reg_rdata == 16'h0000; endproperty
  property p_mapped; rt && reg_addr >= 16'h19ec && reg_addr < 16'h19ec + N_CH |=> !reg_err;
  endproperty
  property p_busy; reg_busy |-> bcnt_r <= N_CH + 2; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_spur: assert property (p_spur) else $error("ack without request");
  a_err: assert property (p_err) else $error("err without ack");
  a_dp: assert property (p_dp) else $error("decimal places above four kept");
  a_flag: assert property (p_flag) else $error("flag above one kept");
  a_osel: assert property (p_osel) else $error("selector above two kept");
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  a_mapped: assert property (p_mapped) else $error("mapped read refused");
  a_busy: assert property (p_busy) else $error("default load too long");
endmodule // chsp_chk

bind chsp_param_bank chsp_chk #(.N_CH(N_CH)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .reg_err(reg_err), .reg_busy(reg_busy), .type_bus(type_bus),
  .range_hi_bus(range_hi_bus), .range_lo_bus(range_lo_bus), .ctrl_in(ctrl_in),
  .logic_in(logic_in), .fail_in(fail_in), .chan_out(chan_out),
  .burnout_down(burnout_down), .sqrt_en(sqrt_en), .dp_bus(dp_bus)
);

/* File: testbench/chsp_tb_top.sv */
`timescale 1ns/1ps
module channel_input_setup_params_tb_top;
  // ****************************************
  // Bench
  // ****************************************
  localparam N = 4;
  reg            mclk, rst_n;
  reg  [N*5-1:0] ty = {5'h13, 5'h0c, 5'h02, 5'h00};
  reg  [N*16-1:0] rh_b = {16'h03e8, 16'h2134, 16'h06e8, 16'h3598};
  reg  [N*16-1:0] rl_b = {16'h0000, 16'hf830, 16'h0000, 16'hf830};
  reg  [N-1:0]   ci = 4'h0, li = 4'h0, fi = 4'h0;
  wire [15:0]    addr, wdata, rdata;
  wire           wr, rd, ack, err, busy;
  wire [N-1:0]   co, bd, se;
  wire [N*3-1:0] dpb;
  integer        n_mismatch = 0, n_compared = 0;
  int            mem [0:8][0:N-1];
  reg  [31:0]    seed = 32'hc09afaa4;
  int tbl [45] = '{1,3,19999, 2,3,-2, 2,3,-1, 1,3,20000, 1,0,13721, 1,0,13720, 2,0,-2001,
    2,1,-1, 1,2,-2001, 3,0,14507, 3,0,14506, 4,0,-2787, 4,0,-2786, 3,1,-89, 4,1,1857};

  chsp_param_bank #(.N_CH(N)) u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_ack(ack),
    .reg_err(err), .reg_busy(busy), .type_bus(ty), .range_hi_bus(rh_b), .range_lo_bus(rl_b),
    .ctrl_in(ci), .logic_in(li), .fail_in(fi), .chan_out(co), .burnout_down(bd),
    .sqrt_en(se), .dp_bus(dpb));
  chsp_host u_host (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .reg_ack(ack), .reg_err(err));

  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic bit okv(int p, int c, int v);
    int t, h, l, m, u;
    bit vi;
    t = ty[c*5+:5];
    h = $signed(rh_b[c*16+:16]);
    l = $signed(rl_b[c*16+:16]);
    m = (h - l) / 20;
    u = v & 32'h0000ffff;
    vi = t >= 14 && t <= 21;
    case (p)
      0: return (t inside {0, 1, 5, 7, 12, 13}) ? u <= 1 : (t <= 9) ? u == 0 : u <= 4;
      1: return vi ? v >= -19999 && v <= 19999 && v - mem[2][c] <= 20000 &&
                     v - mem[2][c] >= -20000 : v >= mem[2][c] && v <= h;
      2: return vi ? v >= -19999 && v <= 19999 && mem[1][c] - v <= 20000 &&
                     mem[1][c] - v >= -20000 : v >= l && v <= mem[1][c];
      3: return v >= mem[4][c] && v <= h + m;
      4: return v >= l - m && v <= mem[3][c];
      7: return u <= 2;
      default: return u <= 1;
    endcase
  endfunction
  task model_reset;
    int t, h, l;
    for (int c = 0; c < N; c++) begin
      t = ty[c*5+:5];
      h = $signed(rh_b[c*16+:16]);
      l = $signed(rl_b[c*16+:16]);
      mem[0][c] = (t <= 9 && !(t inside {0, 1, 5, 7})) ? 0 : 1;
      mem[1][c] = (t >= 14 && t <= 21) ? 1000 : h;
      mem[2][c] = (t >= 14 && t <= 21) ? 0 : l;
      mem[3][c] = h + (h - l) / 20;
      mem[4][c] = l - (h - l) / 20;
      for (int p = 5; p < 9; p++) mem[p][c] = 0;
    end
  endtask
  task chk(input string nm, input logic [63:0] ex, got);
    n_compared++;
    if (got !== ex) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task acc(input bit w, input int p, c, v);
    logic [15:0] q;
    logic k, e;
    bit ok;
    ok = w ? okv(p, c, v) : 1'b1;
    u_host.acc(w, 16'(16'h19ec + p * 64 + c), v[15:0], q, k, e);
    chk("ack", 64'h1, {63'h0, k});
    chk("err", {63'h0, !ok}, {63'h0, e});
    if (w && ok) mem[p][c] = v;
    if (!w) chk("rdata", {48'h0, mem[p][c][15:0]}, {48'h0, q});
  endtask
  task chk_out;
    logic [N-1:0] eo, eb, es;
    logic [N*3-1:0] ed;
    int t;
    repeat (2) @(posedge mclk);
    for (int c = 0; c < N; c++) begin
      t = ty[c*5+:5];
      eo[c] = (mem[7][c] == 0 ? ci[c] : mem[7][c] == 1 ? li[c] : fi[c]) ^ mem[8][c][0];
      eb[c] = mem[5][c][0] && (t <= 9 || (t >= 19 && t <= 21));
      es[c] = mem[6][c][0];
      ed[c*3+:3] = mem[0][c][2:0];
    end
    chk("chan_out", 64'(eo), 64'(co));
    chk("burnout_down", 64'(eb), 64'(bd));
    chk("sqrt_en", 64'(es), 64'(se));
    chk("dp_bus", 64'(ed), 64'(dpb));
  endtask
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    logic [15:0] q;
    logic k, e;
    rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    model_reset;
    u_host.acc(1'b0, 16'h19ec, 16'h0000, q, k, e);
    chk("ack while loading", 64'h0, {63'h0, k});
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge mclk);
    for (int p = 0; p < 9; p++) for (int c = 0; c < N; c++) acc(0, p, c, 0);
    chk_out;
    $display("test defaults done");
    for (int c = 0; c < N; c++) for (int v = 0; v < 6; v++) acc(1, 0, c, v);
    chk_out;
    $display("test decimal places done");
    for (int i = 0; i < 45; i += 3) acc(1, tbl[i], tbl[i+1], tbl[i+2]);
    for (int i = 0; i < 45; i += 3) acc(0, tbl[i], tbl[i+1], 0);
    $display("test limits done");
    repeat (40) begin
      seed = xs(seed);
      acc(1, 5 + seed[1:0], seed[9:8], seed[17:16]);
      ci <= seed[23:20];
      li <= seed[27:24];
      fi <= seed[31:28];
      chk_out;
    end
    $display("test output routing done");
    for (int i = 0; i < 2; i++) begin
      u_host.acc(1'b0, i ? 16'h1c2c : 16'h19eb, 16'h0001, q, k, e);
      chk("unmapped err", 64'h1, {63'h0, e});
      chk("unmapped rdata", 64'h0, {48'h0, q});
    end
    $display("test unmapped done");
    report_and_stop;
  end
endmodule // channel_input_setup_params_tb_top
